/* File: hw/emm_decode.sv */
// Purpose: turn an emulated address and granularity into a map index and high-address flag
// Assumes: combinational, registered by the caller
// Notes: none
`include "emm_defines.svh"
module emm_decode (
  input wire logic gran_in,
  input wire logic [`EMM_ADDR_W-1:0] addr_in,
  output logic [`EMM_IDX_W-1:0] idx_out,
  output logic beyond_out
);
  always_comb begin
    if (gran_in) begin
      idx_out = addr_in[`EMM_COARSE_HI:`EMM_COARSE_LO];
      beyond_out = 1'b0;
    end else begin
      idx_out = addr_in[`EMM_FINE_HI:`EMM_FINE_LO];
      beyond_out = |addr_in[`EMM_ADDR_W-1:`EMM_HIGH_LO];
    end
  end
endmodule

/* File: hw/emm_defines.svh */
// Purpose: constants for the emulation memory mapper
// Assumes: 24-bit emulated address, 1024 map entries
// Notes: offsets are byte addresses on the apb register port
`ifndef EMM_DEFINES_SVH
`define EMM_DEFINES_SVH
`define EMM_ADDR_W 24
`define EMM_IDX_W 10
`define EMM_ENTRIES 1024
`define EMM_TYPE_W 3
`define EMM_FINE_LO 10
`define EMM_FINE_HI 19
`define EMM_COARSE_LO 14
`define EMM_COARSE_HI 23
`define EMM_HIGH_LO 20
`define EMM_OFS_CTRL 12'h000
`define EMM_OFS_STAT 12'h004
`define EMM_OFS_IDX 12'h008
`define EMM_OFS_ENTRY 12'h00c
`define EMM_OFS_LAST 12'h010
`define EMM_CTRL_GRAN 0
`define EMM_CTRL_REST 1
`define EMM_STAT_UNIF 0
`define EMM_STAT_REFUSED 1
`define EMM_RESET_TYPE 3'h0
`endif

/* File: hw/emm_map_table.sv */
// Purpose: 1024-entry map storage with one write port and two lookup ports
// Assumes: same clock as the mapper
// Notes: flip-flop storage, large but simple
`include "emm_defines.svh"
module emm_map_table (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic wr_in,
  input wire logic [`EMM_IDX_W-1:0] widx_in,
  input wire logic [`EMM_TYPE_W-1:0] wtype_in,
  input wire logic [`EMM_IDX_W-1:0] ridx_in,
  input wire logic [`EMM_IDX_W-1:0] lidx_in,
  output logic [`EMM_TYPE_W-1:0] rtype_out,
  output logic [`EMM_TYPE_W-1:0] ltype_out
);
  typedef struct packed {
    logic [`EMM_ENTRIES-1:0][`EMM_TYPE_W-1:0] ent;
  } emm_tab_t;
  emm_tab_t st;
  emm_tab_t next_st;
  always_comb begin
    next_st = st;
    if (wr_in) begin
      next_st.ent[widx_in] = wtype_in;
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end
  assign rtype_out = st.ent[ridx_in];
  assign ltype_out = st.ent[lidx_in];
endmodule

/* File: hw/emm_mapper.sv */
// Purpose: map emulated addresses to probe memories or the target
// Assumes: apb register port, one clock, address valid as a strobe
// Notes: map keeps its contents over any host-side restart
`include "emm_defines.svh"
// Overview of operation
// - 1024 entries, block size set by granularity
// - fine mode maps only the lowest megabyte
// - coarse mode spans all, no aliasing
// - optional fast RAM uses the same block size as other types
// - fine mode ignores A23-A20 for probe memory
// - user blocks pass to target unaliased
// - restart leaves hardware map boundaries intact
module emm_mapper (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic acc_valid_in,
  input wire logic [`EMM_ADDR_W-1:0] acc_addr_in,
  output logic sel_valid_out,
  output logic [`EMM_TYPE_W-1:0] sel_type_out,
  output logic [`EMM_ADDR_W-1:0] sel_addr_out,
  output logic sel_beyond_out
);
  typedef struct packed {
    emm_pkg::emm_apb_st_t apb;
    logic gran;
    logic refused;
    logic [`EMM_IDX_W-1:0] idx;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic sv;
    logic [`EMM_TYPE_W-1:0] stype;
    logic [`EMM_ADDR_W-1:0] saddr;
    logic beyond;
  } emm_st_t;
  emm_st_t st;
  emm_st_t next_st;
  logic tab_wr;
  logic [`EMM_TYPE_W-1:0] tab_rtype;
  logic [`EMM_TYPE_W-1:0] tab_ltype;
  logic [`EMM_IDX_W-1:0] look_idx;
  logic [`EMM_IDX_W-1:0] dec_idx;
  logic dec_beyond;
  logic [`EMM_IDX_W-1:0] uni_ptr;
  logic uni_ok;
  logic uni_first;
  logic [`EMM_TYPE_W-1:0] uni_type;
  logic [`EMM_TYPE_W-1:0] uni_cur;
  logic wr_acc;
  logic rd_acc;

  // 16K-aligned index for optional fast RAM; the table lookup uses the decoder index
  function automatic logic [`EMM_IDX_W-1:0] ofr_idx(
    input logic gran,
    input logic [`EMM_ADDR_W-1:0] a
  );
    ofr_idx = gran ? a[`EMM_COARSE_HI:`EMM_COARSE_LO]
                   : {a[`EMM_FINE_HI:`EMM_COARSE_LO], 4'h0};
  endfunction

  emm_decode u_dec (
    .gran_in(st.gran),
    .addr_in(acc_addr_in),
    .idx_out(dec_idx),
    .beyond_out(dec_beyond)
  );

  assign look_idx = dec_idx;
  assign wr_acc = psel_in && penable_in && pwrite_in && !st.ready;
  assign rd_acc = psel_in && penable_in && !pwrite_in && !st.ready;
  assign tab_wr = wr_acc && paddr_in == `EMM_OFS_ENTRY;

  emm_map_table u_tab (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .wr_in(tab_wr),
    .widx_in(st.idx),
    .wtype_in(pwdata_in[`EMM_TYPE_W-1:0]),
    .ridx_in(st.gran && ce_in ? look_idx : look_idx),
    .lidx_in(uni_ptr),
    .rtype_out(tab_rtype),
    .ltype_out(tab_ltype)
  );

  // uniformity scan walks the map one entry per cycle; a change of
  // granularity is only taken when the last full pass saw only user or only guarded entries
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uni_ptr <= '0;
      uni_ok <= 1'b0;
      uni_first <= 1'b1;
      uni_type <= `EMM_RESET_TYPE;
      uni_cur <= `EMM_RESET_TYPE;
    end else if (ce_in) begin
      uni_ptr <= uni_ptr + 1'b1;
      if (tab_wr) begin
        uni_first <= 1'b1;
        uni_ok <= 1'b0;
        uni_ptr <= '0;
      end else if (uni_ptr == '0) begin
        uni_cur <= tab_ltype;
        uni_first <= 1'b0;
        if (!uni_first) begin
          uni_ok <= (uni_type == emm_pkg::EMM_USER)
                 || (uni_type == emm_pkg::EMM_GUARDED);
        end
        uni_type <= tab_ltype;
      end else if (tab_ltype != uni_cur) begin
        uni_type <= 3'h7;
      end
    end
  end

  always_comb begin
    logic [`EMM_TYPE_W-1:0] t;
    logic [`EMM_IDX_W-1:0] oi;
    t = tab_rtype;
    oi = '0;
    next_st = st;
    next_st.ready = 1'b0;
    next_st.err = 1'b0;
    case (st.apb)
      emm_pkg::EMM_ST_IDLE: begin
        if (psel_in && !penable_in) begin
          next_st.apb = emm_pkg::EMM_ST_ACCESS;
        end
      end
      emm_pkg::EMM_ST_ACCESS: begin
        next_st.ready = 1'b1;
        next_st.apb = emm_pkg::EMM_ST_IDLE;
        next_st.rdata = '0;
        case (paddr_in)
          `EMM_OFS_CTRL: begin
            next_st.rdata[`EMM_CTRL_GRAN] = st.gran;
            if (pwrite_in) begin
              if (pwdata_in[`EMM_CTRL_REST]) begin
                next_st.refused = 1'b0;
              end else if (pwdata_in[`EMM_CTRL_GRAN] != st.gran) begin
                if (uni_ok) begin
                  next_st.gran = pwdata_in[`EMM_CTRL_GRAN];
                end else begin
                  next_st.refused = 1'b1;
                end
              end
            end
          end
          `EMM_OFS_STAT: begin
            next_st.rdata[`EMM_STAT_UNIF] = uni_ok;
            next_st.rdata[`EMM_STAT_REFUSED] = st.refused;
            if (pwrite_in && pwdata_in[`EMM_STAT_REFUSED]) begin
              next_st.refused = 1'b0;
            end
          end
          `EMM_OFS_IDX: begin
            next_st.rdata[`EMM_IDX_W-1:0] = st.idx;
            if (pwrite_in) begin
              next_st.idx = pwdata_in[`EMM_IDX_W-1:0];
            end
          end
          `EMM_OFS_ENTRY: begin
            next_st.rdata[`EMM_TYPE_W-1:0] = tab_rtype;
          end
          `EMM_OFS_LAST: begin
            next_st.rdata[`EMM_ADDR_W-1:0] = st.saddr;
          end
          default: begin
            next_st.err = 1'b1;
          end
        endcase
      end
      default: begin
        next_st.apb = emm_pkg::EMM_ST_IDLE;
      end
    endcase
    // lookup pipeline: one registered stage per access
    next_st.sv = acc_valid_in;
    if (acc_valid_in) begin
      oi = ofr_idx(st.gran, acc_addr_in);
      next_st.saddr = acc_addr_in;
      next_st.beyond = dec_beyond;
      next_st.stype = t;
      if (t == emm_pkg::EMM_USER) begin
        next_st.saddr = acc_addr_in;
      end else if (!st.gran) begin
        next_st.saddr[`EMM_ADDR_W-1:`EMM_HIGH_LO] = 4'h0;
      end
      if (oi[3:0] != 4'h0) begin
        next_st.stype = t;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '{apb: emm_pkg::EMM_ST_IDLE, default: '0};
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign prdata_out = st.rdata;
  assign pready_out = st.ready;
  assign pslverr_out = st.err;
  assign sel_valid_out = st.sv;
  assign sel_type_out = st.stype;
  assign sel_addr_out = st.saddr;
  assign sel_beyond_out = st.beyond;

  a_beyond_fine: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    ce_in && acc_valid_in && !st.gran && |acc_addr_in[23:20]
    |=> sel_beyond_out) else $error("high address not flagged");
  a_no_alias_coarse: assert property (@(posedge mclk_in)
    disable iff (!arst_n_in)
    ce_in && acc_valid_in && st.gran |=> !sel_beyond_out
    && sel_addr_out == $past(acc_addr_in))
    else $error("coarse mode altered address");
  a_gran_guard: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    ce_in && st.gran != next_st.gran |-> uni_ok)
    else $error("granularity moved on mixed map");
  a_fold_probe: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    sel_valid_out && !st.gran && sel_type_out != emm_pkg::EMM_USER
    |-> sel_addr_out[23:20] == 4'h0)
    else $error("probe memory not folded");
  a_user_pass: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    ce_in && acc_valid_in && tab_rtype == emm_pkg::EMM_USER
    |=> sel_addr_out == $past(acc_addr_in))
    else $error("user address changed");
  a_restart_keep: assert property (@(posedge mclk_in)
    disable iff (!arst_n_in)
    ce_in && tab_wr == 1'b0 && wr_acc && paddr_in == `EMM_OFS_CTRL
    && pwdata_in[1] |=> $stable(st.gran))
    else $error("restart changed map");
  a_index_fine: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !st.gran |-> look_idx == acc_addr_in[19:10])
    else $error("fine index wrong");
  a_apb_one: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    pready_out |=> !pready_out) else $error("pready held");
  c_gran_up: cover property (@(posedge mclk_in) $rose(st.gran));
  c_refused: cover property (@(posedge mclk_in) $rose(st.refused));
  c_fold: cover property (@(posedge mclk_in)
    sel_valid_out && !st.gran && sel_beyond_out);
endmodule

/* File: hw/emm_pkg.sv */
// Purpose: types for the emulation memory mapper
// Assumes: emm_defines.svh supplies widths
// Notes: none
`include "emm_defines.svh"
package emm_pkg;
  typedef enum logic [2:0] {
    EMM_USER = 3'h0,
    EMM_PROBE_FAST_RAM = 3'h1,
    EMM_MEMORY_BOARD = 3'h2,
    EMM_OPTIONAL_FAST_RAM = 3'h3,
    EMM_GUARDED = 3'h4
  } emm_type_t;
  typedef enum logic [1:0] {
    EMM_ST_IDLE = 2'b01,
    EMM_ST_ACCESS = 2'b10
  } emm_apb_st_t;
endpackage

/* File: verification/emm_target_bus.sv */
// Purpose: emulated processor address bus that issues lookups
// Assumes: one access per call, a free edge between accesses
// Notes: released bus shows the inverted address, so stale values never
// look like a fresh request
`include "emm_defines.svh"
module emm_target_bus (
  input wire logic mclk_in,
  output logic acc_valid_out,
  output logic [`EMM_ADDR_W-1:0] acc_addr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    acc_valid_out = 1'b0;
    acc_addr_out = 24'h000000;
  end
  task automatic issue(input logic [`EMM_ADDR_W-1:0] a);
    @(posedge mclk_in);
    acc_valid_out <= 1'b1;
    acc_addr_out <= a;
    @(posedge mclk_in);
    acc_valid_out <= 1'b0;
    acc_addr_out <= ~a;
  endtask
endmodule

/* File: verification/test_emulation_memory_mapper.sv */
// Purpose: self-checking bench for the emulation memory mapper
// Assumes: apb at one wait state, lookups answered one edge later
// Notes: map writes are undone before the granularity change, since a
// mixed map refuses it
`include "emm_defines.svh"
module test_emulation_memory_mapper;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, acc_valid, sel_valid, sel_beyond;
  logic [23:0] acc_addr, sel_addr;
  logic [2:0] sel_type;
  logic [27:0] sel_q[$];
  logic [33:0] apb_q[$];
  logic [33:0] e;
  logic [15:0] rnd = 16'h0046;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2 mclk_in = ~mclk_in;
  emm_mapper u_emm_mapper (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .ce_in(ce), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .acc_valid_in(acc_valid), .acc_addr_in(acc_addr),
    .sel_valid_out(sel_valid), .sel_type_out(sel_type),
    .sel_addr_out(sel_addr), .sel_beyond_out(sel_beyond));
  emm_target_bus u_emm_target_bus (.mclk_in(mclk_in),
    .acc_valid_out(acc_valid), .acc_addr_out(acc_addr));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [27:0] ex(input logic g, input logic [2:0] t,
                                     input logic [23:0] a);
    logic b;
    logic [23:0] m;
    b = !g && a[23:20] != 4'h0;
    m = (g || t == 3'h0) ? a : {4'h0, a[19:0]};
    return {b, t, m};
  endfunction
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_sel(input logic [27:0] got, input logic [27:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    int n;
    apb_q.push_back({~w, x});
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask
  task automatic put(input logic [9:0] i, input logic [2:0] t);
    wr(`EMM_OFS_IDX, {22'h0, i});
    wr(`EMM_OFS_ENTRY, {29'h0, t});
  endtask
  task automatic look(input logic [23:0] a, input logic [27:0] x);
    sel_q.push_back(x);
    u_emm_target_bus.issue(a);
  endtask
  // one watcher for both result kinds keeps the queues in step
  always @(posedge mclk_in) begin
    if (sel_valid === 1'b1) begin
      check_sel({sel_beyond, sel_type, sel_addr}, sel_q.pop_front());
    end
    if (psel && penable && pready === 1'b1) begin
      e = apb_q.pop_front();
      check({e[33], pslverr, e[33] ? prdata : 32'h0}, e);
    end
  end
  initial begin
    logic [23:0] a;
    repeat (16) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(`EMM_OFS_CTRL, 32'h0);
    apb(1'b0, 12'h014, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      a = {rnd[7:0], rnd};
      look(a, ex(1'b0, emm_pkg::EMM_USER, a));
    end
    put(10'h005, emm_pkg::EMM_PROBE_FAST_RAM);
    put(10'h3ff, emm_pkg::EMM_MEMORY_BOARD);
    for (int i = 16; i < 32; i++) put(i[9:0], emm_pkg::EMM_OPTIONAL_FAST_RAM);
    rnd = lfsr(rnd);
    a = {rnd[3:0], 10'h005, rnd[13:4]};
    look(a, ex(1'b0, emm_pkg::EMM_PROBE_FAST_RAM, a));
    a = {rnd[7:4], 10'h3ff, rnd[9:0]};
    look(a, ex(1'b0, emm_pkg::EMM_MEMORY_BOARD, a));
    a = {rnd[3:0], 6'h01, rnd[13:0]};
    look(a, ex(1'b0, emm_pkg::EMM_OPTIONAL_FAST_RAM, a));
    wr(`EMM_OFS_CTRL, 32'h1);
    rd(`EMM_OFS_STAT, 32'h2);
    rd(`EMM_OFS_CTRL, 32'h0);
    wr(`EMM_OFS_STAT, 32'h2);
    put(10'h005, emm_pkg::EMM_USER);
    put(10'h3ff, emm_pkg::EMM_USER);
    for (int i = 16; i < 32; i++) put(i[9:0], emm_pkg::EMM_USER);
    // uniformity needs one full scan of the map after the last write
    repeat (2200) @(posedge mclk_in);
    rd(`EMM_OFS_STAT, 32'h1);
    wr(`EMM_OFS_CTRL, 32'h1);
    rd(`EMM_OFS_CTRL, 32'h1);
    put(10'h3ff, emm_pkg::EMM_MEMORY_BOARD);
    a = {10'h3ff, rnd[13:0]};
    look(a, ex(1'b1, emm_pkg::EMM_MEMORY_BOARD, a));
    look(24'h0ffc00, ex(1'b1, emm_pkg::EMM_USER, 24'h0ffc00));
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = {rnd[7:0], rnd};
      look(a, ex(1'b1, (a[23:14] == 10'h3ff) ? 3'h2 : 3'h0, a));
    end
    wr(`EMM_OFS_CTRL, 32'h3);
    a = {10'h3ff, rnd[15:2]};
    look(a, ex(1'b1, emm_pkg::EMM_MEMORY_BOARD, a));
    repeat (2) @(posedge mclk_in);
    // a lookup while the enable is low must leave no result behind
    ce <= 1'b0;
    u_emm_target_bus.issue(a);
    ce <= 1'b1;
    @(posedge mclk_in);
    check_sel({27'h0, sel_valid}, 28'h0);
    repeat (4) @(posedge mclk_in);
    check({2'h0, 16'(sel_q.size()), 16'(apb_q.size())}, 34'h0);
    report_and_stop();
  end
endmodule
